// *** include/jit_pkg.sv ***
// shared types and constants of the jitter fifo front end
package jit_pkg;
   localparam int NUM_CH        = 3;
   localparam int DEPTH_SMALL   = 16;
   localparam int DEPTH_LARGE   = 32;
   localparam int PTR_W         = 5;
   localparam int ADDR_W        = 8;
   localparam int DATA_W        = 8;
   localparam int CMD_BITS      = 1 + ADDR_W;
   localparam int FRAME_BITS    = CMD_BITS + DATA_W;
   localparam int NUM_CMD_REGS  = 8;
   localparam int unsigned OUT_DIV_RST = 16'h0004;
   localparam logic [DATA_W-1:0] CMD_REG_RST = 8'h00;

   typedef struct packed {
      logic pos;
      logic neg;
   } rail_pair_t;

   typedef struct packed {
      logic rd_n_wr;
      logic [ADDR_W-1:0] addr;
   } host_cmd_t;
endpackage : jit_pkg

// *** core/rail_skid.sv ***
// two-entry buffer for rail pairs between the fifo and the output shifter
module rail_skid
   import jit_pkg::*;
(
   input  wire logic       clk_sys_i,
   input  wire logic       rstn_i,
   input  wire rail_pair_t in_data_i,
   input  wire logic       in_valid_i,
   output logic            in_ready_o,
   output rail_pair_t      out_data_o,
   output logic            out_valid_o,
   input  wire logic       out_ready_i
);
   typedef struct packed {
      rail_pair_t [1:0] mem;
      logic             wr;
      logic             rd;
      logic [1:0]       cnt;
   } skid_state_t;

   skid_state_t s_r, s_nxt;

   always_comb begin
      logic push;
      logic pop;
      push  = 1'b0;
      pop   = 1'b0;
      s_nxt = s_r;
      push  = in_valid_i && (s_r.cnt != 2'd2);
      pop   = out_ready_i && (s_r.cnt != 2'd0);
      if (push) begin
         s_nxt.mem[s_r.wr] = in_data_i;
         s_nxt.wr          = ~s_r.wr;
      end
      if (pop) begin
         s_nxt.rd = ~s_r.rd;
      end
      s_nxt.cnt = s_r.cnt + {1'b0, push} - {1'b0, pop};
   end

   always_ff @(posedge clk_sys_i or negedge rstn_i) begin
      if (!rstn_i) begin
         s_r <= '0;
      end else begin
         s_r <= s_nxt;
      end
   end

   assign in_ready_o  = (s_r.cnt != 2'd2);
   assign out_valid_o = (s_r.cnt != 2'd0);
   assign out_data_o  = s_r.mem[s_r.rd];
endmodule : rail_skid

// *** core/jitter_fifo_front.sv ***
// three-channel elastic fifo front end with serial host port
// Overview of operation
// - the fifo holds 32 entries when depth select is high, 16 when low.
// - a host read shifts the addressed command register out on the serial output.
// - the serial output changes on each falling edge of the shift clock.
// - the serial output is released to high impedance once a transfer ends.
// - the serial input is sampled on each rising edge of the shift clock.
// - in hardware mode one capture edge selection governs all three channels; host mode always captures on the rising edge.
// - the shared pin is channel 1 bypass in hardware mode, serial input in host mode.
// - chip select low enables the serial port; activity while high is ignored.
module jitter_fifo_front
   import jit_pkg::*;
#(
   parameter int OUT_DIV = OUT_DIV_RST
)(
   input  wire logic              clk_sys_i,
   input  wire logic              rstn_i,
   input  wire logic              host_mode_i,
   input  wire logic              fifo_depth_select_i,
   input  wire logic              capture_edge_select_i,
   input  wire logic [NUM_CH-1:0] rx_clk_i,
   input  wire logic [NUM_CH-1:0] rx_pos_rail_i,
   input  wire logic [NUM_CH-1:0] rx_neg_rail_i,
   input  wire logic              bypass_or_sdi_i,
   input  wire logic              host_cs_n_i,
   input  wire logic              host_sclk_i,
   output logic                   host_serial_out_o,
   output logic                   host_serial_out_oe_o,
   output logic [NUM_CH-1:0]      dejittered_clock_out_o,
   output logic [NUM_CH-1:0]      dejittered_pos_out_o,
   output logic [NUM_CH-1:0]      dejittered_neg_out_o,
   output logic                   attenuator_bypass_ch1_o
);
   import jit_pkg::*;

   // the divider is 16 bits and needs at least two cycles per half period
   if (OUT_DIV < 2 || OUT_DIV > 65535) begin : g_bad_div
      $error("OUT_DIV out of range");
   end

   typedef struct packed {
      logic [NUM_CH-1:0] clk_m;
      logic [NUM_CH-1:0] clk_s;
      logic [NUM_CH-1:0] clk_d;
      logic [NUM_CH-1:0] pos_m;
      logic [NUM_CH-1:0] pos_s;
      logic [NUM_CH-1:0] neg_m;
      logic [NUM_CH-1:0] neg_s;
      logic [2:0]        hc_m;
      logic [2:0]        hc_s;
      logic              sclk_d;
      logic [2:0]        cfg_m;
      logic [2:0]        cfg_s;
      logic [2:0]        arm;
      logic [15:0]       div;
      logic [NUM_CH-1:0] oclk;
      logic [NUM_CH-1:0] opos;
      logic [NUM_CH-1:0] oneg;
      logic              bypass;
      logic [4:0]        bitn;
      logic [FRAME_BITS-1:0] shin;
      logic [DATA_W-1:0] shout;
      logic              host_serial_out;
      logic              sdo_oe;
      logic [NUM_CMD_REGS-1:0][DATA_W-1:0] cmd;
   } top_state_t;

   typedef struct packed {
      rail_pair_t [DEPTH_LARGE-1:0] mem;
      logic [PTR_W-1:0]             wp;
      logic [PTR_W-1:0]             rp;
      logic [PTR_W:0]               cnt;
   } chan_fifo_t;

   top_state_t s_r, s_nxt;
   chan_fifo_t [NUM_CH-1:0] f_r, f_nxt;

   rail_pair_t [NUM_CH-1:0] sk_in;
   logic       [NUM_CH-1:0] sk_in_valid;
   logic       [NUM_CH-1:0] sk_in_ready;
   rail_pair_t [NUM_CH-1:0] sk_out;
   logic       [NUM_CH-1:0] sk_out_valid;
   logic       [NUM_CH-1:0] sk_pop;

   function automatic logic [PTR_W:0] depth_of(input logic sel);
      depth_of = sel ? (PTR_W+1)'(DEPTH_LARGE) : (PTR_W+1)'(DEPTH_SMALL);
   endfunction : depth_of

   function automatic logic [PTR_W-1:0] ptr_inc(input logic [PTR_W-1:0] p,
                                                input logic sel);
      ptr_inc = (p == PTR_W'(depth_of(sel) - 1'b1)) ? '0 : p + 1'b1;
   endfunction : ptr_inc

   genvar gi;
   generate
      for (gi = 0; gi < NUM_CH; gi++) begin : g_skid
         rail_skid u_skid (
            .clk_sys_i   (clk_sys_i),
            .rstn_i      (rstn_i),
            .in_data_i   (sk_in[gi]),
            .in_valid_i  (sk_in_valid[gi]),
            .in_ready_o  (sk_in_ready[gi]),
            .out_data_o  (sk_out[gi]),
            .out_valid_o (sk_out_valid[gi]),
            .out_ready_i (sk_pop[gi])
         );
      end
   endgenerate

   always_comb begin
      logic [NUM_CH-1:0] cap;
      logic              tick;
      logic              host_on;
      logic              sclk_rise;
      logic              sclk_fall;
      logic              push;
      logic              pop;
      logic              dsel;
      logic              esel;
      logic [ADDR_W-1:0] a;
      cap       = '0;
      tick      = 1'b0;
      host_on   = s_r.cfg_s[2];
      sclk_rise = 1'b0;
      sclk_fall = 1'b0;
      dsel      = s_r.cfg_s[1];
      esel      = s_r.cfg_s[0];
      push      = 1'b0;
      pop       = 1'b0;
      a         = '0;
      s_nxt     = s_r;
      f_nxt     = f_r;
      sk_in     = '0;
      sk_in_valid = '0;
      sk_pop    = '0;
      s_nxt.clk_m = rx_clk_i;
      s_nxt.clk_s = s_r.clk_m;
      s_nxt.clk_d = s_r.clk_s;
      s_nxt.pos_m = rx_pos_rail_i;
      s_nxt.pos_s = s_r.pos_m;
      s_nxt.neg_m = rx_neg_rail_i;
      s_nxt.neg_s = s_r.neg_m;
      s_nxt.hc_m  = {host_cs_n_i, host_sclk_i, bypass_or_sdi_i};
      s_nxt.hc_s  = s_r.hc_m;
      s_nxt.sclk_d = s_r.hc_s[1];
      // straps are static but still come from the board
      s_nxt.cfg_m = {host_mode_i, fifo_depth_select_i, capture_edge_select_i};
      s_nxt.cfg_s = s_r.cfg_m;
      // edge history is bogus until it holds real pin values
      s_nxt.arm   = {s_r.arm[1:0], 1'b1};
      for (int c = 0; c < NUM_CH; c++) begin
         if (!s_r.arm[2]) begin
            cap[c] = 1'b0;
         end else if (esel && !host_on) begin
            cap[c] = s_r.clk_d[c] && !s_r.clk_s[c];
         end else begin
            cap[c] = !s_r.clk_d[c] && s_r.clk_s[c];
         end
      end
      // shared out-divider: all channels leave at one steady rate
      tick = (s_r.div == 16'(OUT_DIV - 1));
      s_nxt.div = tick ? '0 : s_r.div + 16'd1;
      for (int c = 0; c < NUM_CH; c++) begin
         push = cap[c] && (f_r[c].cnt < depth_of(dsel));
         pop  = (f_r[c].cnt != '0) && sk_in_ready[c];
         sk_in[c]       = f_r[c].mem[f_r[c].rp];
         sk_in_valid[c] = (f_r[c].cnt != '0);
         if (push) begin
            f_nxt[c].mem[f_r[c].wp] = '{pos: s_r.pos_s[c], neg: s_r.neg_s[c]};
            f_nxt[c].wp = ptr_inc(f_r[c].wp, dsel);
         end
         if (pop) begin
            f_nxt[c].rp = ptr_inc(f_r[c].rp, dsel);
         end
         f_nxt[c].cnt = f_r[c].cnt + {PTR_W'(0), push} - {PTR_W'(0), pop};
         // data changes with falling out clock
         if (tick) begin
            s_nxt.oclk[c] = ~s_r.oclk[c];
            if (s_r.oclk[c] && sk_out_valid[c]) begin
               s_nxt.opos[c] = sk_out[c].pos;
               s_nxt.oneg[c] = sk_out[c].neg;
               sk_pop[c]     = 1'b1;
            end
         end
      end
      s_nxt.bypass = host_on ? 1'b0 : s_r.hc_s[0];
      sclk_rise = s_r.arm[2] && s_r.hc_s[1] && !s_r.sclk_d;
      sclk_fall = s_r.arm[2] && !s_r.hc_s[1] && s_r.sclk_d;
      if (!host_on || s_r.hc_s[2]) begin
         s_nxt.bitn   = '0;
         s_nxt.sdo_oe = 1'b0;
      end else begin
         if (sclk_rise && s_r.bitn < 5'(FRAME_BITS)) begin
            s_nxt.shin = {s_r.shin[FRAME_BITS-2:0], s_r.hc_s[0]};
            s_nxt.bitn = s_r.bitn + 5'd1;
            if (s_r.bitn == 5'(FRAME_BITS - 1) && !s_r.shin[FRAME_BITS-2]) begin
               a = s_r.shin[FRAME_BITS-3 -: ADDR_W];
               s_nxt.cmd[a[2:0]] = {s_r.shin[DATA_W-2:0], s_r.hc_s[0]};
            end
         end
         if (sclk_fall) begin
            if (s_r.bitn == 5'(CMD_BITS) && s_r.shin[CMD_BITS-1]) begin
               a = s_r.shin[ADDR_W-1:0];
               s_nxt.host_serial_out    = s_r.cmd[a[2:0]][DATA_W-1];
               s_nxt.shout  = {s_r.cmd[a[2:0]][DATA_W-2:0], 1'b0};
               s_nxt.sdo_oe = 1'b1;
            end else if (s_r.sdo_oe && s_r.bitn < 5'(FRAME_BITS)) begin
               s_nxt.host_serial_out   = s_r.shout[DATA_W-1];
               s_nxt.shout = {s_r.shout[DATA_W-2:0], 1'b0};
            end else if (s_r.bitn == 5'(FRAME_BITS)) begin
               s_nxt.sdo_oe = 1'b0;
            end
         end
      end
   end

   always_ff @(posedge clk_sys_i or negedge rstn_i) begin
      if (!rstn_i) begin
         s_r <= '0;
         f_r <= '0;
      end else begin
         s_r <= s_nxt;
         f_r <= f_nxt;
      end
   end

   assign host_serial_out_o       = s_r.host_serial_out;
   assign host_serial_out_oe_o    = s_r.sdo_oe;
   assign dejittered_clock_out_o  = s_r.oclk;
   assign dejittered_pos_out_o    = s_r.opos;
   assign dejittered_neg_out_o    = s_r.oneg;
   assign attenuator_bypass_ch1_o = s_r.bypass;
endmodule : jitter_fifo_front

// *** verification/line_src_model.sv ***
// line receiver model: recovered clock and rail data for all channels
module line_src (
   input  wire logic       run_i,
   input  wire logic       sel_i,
   input  wire logic [1:0] word_i,
   output logic [2:0]      rclk_o,
   output logic [2:0]      pos_o,
   output logic [2:0]      neg_o
);
   timeunit 1ns;
   timeprecision 1ps;
   initial begin
      rclk_o = 3'h0;
      pos_o  = 3'h0;
      neg_o  = 3'h0;
   end
   // free running 80 ns line clock
   always #40 if (run_i) rclk_o = {3{~rclk_o[0]}};
   always @(rclk_o[0]) if (rclk_o[0] === sel_i) begin
      pos_o <= {3{word_i[1]}};
      neg_o <= {3{word_i[0]}};
   end
endmodule : line_src

// *** verification/jitter_fifo_front_asserts.sv ***
// port checks for the jitter fifo front end
module jitter_fifo_front_asserts #(
   parameter int OUT_DIV = 4
)(
   input wire logic       clk_sys_i,
   input wire logic       rstn_i,
   input wire logic       host_mode_i,
   input wire logic       bypass_or_sdi_i,
   input wire logic       host_cs_n_i,
   input wire logic       host_sclk_i,
   input wire logic       host_serial_out_o,
   input wire logic       host_serial_out_oe_o,
   input wire logic [2:0] dejittered_clock_out_o,
   input wire logic [2:0] dejittered_pos_out_o,
   input wire logic [2:0] dejittered_neg_out_o,
   input wire logic       attenuator_bypass_ch1_o
);
   default clocking @(posedge clk_sys_i); endclocking
   default disable iff (!rstn_i);
   logic        prev_r;
   int unsigned gap_r;
   // gap 0 means no toggle seen yet since reset
   always_ff @(posedge clk_sys_i or negedge rstn_i) begin
      if (!rstn_i) begin
         prev_r <= 1'b0;
         gap_r  <= 0;
      end else begin
         prev_r <= dejittered_clock_out_o[0];
         gap_r  <= (prev_r != dejittered_clock_out_o[0]) ? 1 : (gap_r == 0 ? 0 : gap_r + 1);
      end
   end
   property p_cs_off; host_cs_n_i [*8] |-> !host_serial_out_oe_o; endproperty
   a_cs_off: assert property (p_cs_off) else $error("serial out driven while deselected");
   property p_done_off; $rose(host_cs_n_i) |-> ##[1:8] !host_serial_out_oe_o; endproperty
   a_done_off: assert property (p_done_off) else $error("serial out not released");
   property p_oe_start;
      $rose(host_serial_out_oe_o) |-> !host_cs_n_i && host_mode_i && !host_sclk_i;
   endproperty
   a_oe_start: assert property (p_oe_start) else $error("serial out started badly");
   property p_sdo_fall;
      $changed(host_serial_out_o) && host_serial_out_oe_o && $past(host_serial_out_oe_o)
         |-> !host_sclk_i;
   endproperty
   a_sdo_fall: assert property (p_sdo_fall) else $error("serial out moved off falling");
   property p_byp_host; host_mode_i [*5] |-> !attenuator_bypass_ch1_o; endproperty
   a_byp_host: assert property (p_byp_host) else $error("bypass set in host mode");
   property p_byp_hw;
      (!host_mode_i && $stable(bypass_or_sdi_i)) [*6] |-> attenuator_bypass_ch1_o == bypass_or_sdi_i;
   endproperty
   a_byp_hw: assert property (p_byp_hw) else $error("bypass not following pin");
   property p_clk_half;
      (prev_r != dejittered_clock_out_o[0]) && gap_r != 0 |-> gap_r == OUT_DIV;
   endproperty
   a_clk_half: assert property (p_clk_half) else $error("output clock half period wrong");
   property p_data_fall;
      (((dejittered_pos_out_o ^ $past(dejittered_pos_out_o)) | (dejittered_neg_out_o ^
         $past(dejittered_neg_out_o))) & ~($past(dejittered_clock_out_o) &
         ~dejittered_clock_out_o)) == 3'h0;
   endproperty
   a_data_fall: assert property (p_data_fall) else $error("output data moved off falling");
endmodule : jitter_fifo_front_asserts
bind jitter_fifo_front jitter_fifo_front_asserts #(.OUT_DIV(OUT_DIV)) jitter_fifo_front_asserts_inst (
   .clk_sys_i, .rstn_i, .host_mode_i, .bypass_or_sdi_i, .host_cs_n_i, .host_sclk_i,
   .host_serial_out_o, .host_serial_out_oe_o, .dejittered_clock_out_o,
   .dejittered_pos_out_o, .dejittered_neg_out_o, .attenuator_bypass_ch1_o);

// *** verification/tb_top.sv ***
// testbench for the jitter fifo front end
module tb_top;
   timeunit 1ns;
   timeprecision 1ps;
   logic clk_sys_i = 0, rstn_i = 0, host_mode = 0, depth_sel = 1, edge_sel = 0;
   logic host_serial_in = 0, cs_n = 1, sclk = 0, host_serial_out, sdo_oe, byp;
   logic [1:0] word = 2'h2;
   logic [2:0] rclk, pos, neg, dclk, dpos, dneg;
   int err_count = 0, compares = 0, cyc = 0;
   always #5 clk_sys_i = ~clk_sys_i;
   line_src line_src_inst (.run_i(1'b1), .sel_i(edge_sel), .word_i(word), .rclk_o(rclk),
      .pos_o(pos), .neg_o(neg));
   // output slower than the line so the fifo can fill up
   jitter_fifo_front #(.OUT_DIV(8)) jitter_fifo_front_inst (.clk_sys_i(clk_sys_i),
      .rstn_i(rstn_i),
      .host_mode_i(host_mode), .fifo_depth_select_i(depth_sel),
      .capture_edge_select_i(edge_sel), .rx_clk_i(rclk), .rx_pos_rail_i(pos),
      .rx_neg_rail_i(neg), .bypass_or_sdi_i(host_serial_in), .host_cs_n_i(cs_n), .host_sclk_i(sclk),
      .host_serial_out_o(host_serial_out), .host_serial_out_oe_o(sdo_oe), .dejittered_clock_out_o(dclk),
      .dejittered_pos_out_o(dpos), .dejittered_neg_out_o(dneg),
      .attenuator_bypass_ch1_o(byp));
   task automatic check(input string what, input logic [7:0] seen, exp);
      compares++;
      if (seen !== exp) begin
         err_count++;
         $display("unexpected %s: expected %h, seen %h", what, exp, seen);
      end
   endtask : check
   task automatic wrap_up();
      $display("compares %0d, mismatches %0d", compares, err_count);
      if (err_count == 0 && compares > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   endtask : wrap_up
   task automatic wait_cyc(input int n);
      repeat (n) @(negedge clk_sys_i);
   endtask : wait_cyc
   // one 17-bit frame, msb first; shift clock half period 250 ns
   task automatic frame(input logic [16:0] f, input logic csv, output logic [7:0] rd);
      cs_n = csv;
      wait_cyc(10);
      for (int i = 16; i >= 0; i--) begin
         sclk = 0;
         host_serial_in = f[i];
         wait_cyc(25);
         if (i < 8) rd[i] = host_serial_out;
         sclk = 1;
         wait_cyc(25);
      end
      sclk = 0;
      wait_cyc(25);
      check("oe after frame", {7'h0, sdo_oe}, 8'h0);
      cs_n = 1;
      wait_cyc(30);
   endtask : frame
   task automatic test_bypass();
      host_serial_in = 1;
      wait_cyc(10);
      check("bypass high", {7'h0, byp}, 8'h1);
      host_serial_in = 0;
      wait_cyc(10);
      check("bypass low", {7'h0, byp}, 8'h0);
      $display("test bypass done");
   endtask : test_bypass
   task automatic test_rails();
      for (int e = 0; e < 2; e++) begin
         edge_sel = e[0];
         depth_sel = e[0];
         word = e[0] ? 2'h1 : 2'h2;
         wait_cyc(800);
         check("pos out", {5'h0, dpos}, {5'h0, {3{word[1]}}});
         check("neg out", {5'h0, dneg}, {5'h0, {3{word[0]}}});
      end
      $display("test rails done");
   endtask : test_rails
   // stale pairs still queued after the line data flips: depth plus buffer
   task automatic test_depth();
      int n;
      int dep;
      for (int d = 0; d < 2; d++) begin
         n = 0;
         dep = d ? jit_pkg::DEPTH_LARGE : jit_pkg::DEPTH_SMALL;
         rstn_i = 0;
         depth_sel = d[0];
         word = 2'h2;
         wait_cyc(3);
         check("clock out in reset", {5'h0, dclk}, 8'h0);
         rstn_i = 1;
         wait_cyc(700);
         word = 2'h1;
         while (dpos[0] === 1'b1 && n < 60) begin
            @(negedge dclk[0]);
            @(negedge clk_sys_i);
            n++;
         end
         check("stale pairs", {7'h0, (n > dep) && (n <= dep + 6)}, 8'h1);
      end
      $display("test depth done");
   endtask : test_depth
   task automatic test_host();
      logic [7:0] rd;
      // edge select low in host mode
      edge_sel = 0;
      host_mode = 1;
      wait_cyc(10);
      frame({1'b1, 8'h05, 8'h00}, 0, rd);
      check("reg 5 reset", rd, jit_pkg::CMD_REG_RST);
      frame({1'b0, 8'h03, 8'ha5}, 0, rd);
      frame({1'b1, 8'h03, 8'h00}, 0, rd);
      check("reg 3 read", rd, 8'ha5);
      frame({1'b0, 8'h03, 8'h3c}, 1, rd);
      frame({1'b1, 8'h03, 8'h00}, 0, rd);
      check("reg 3 kept", rd, 8'ha5);
      check("bypass in host", {7'h0, byp}, 8'h0);
      $display("test host done");
   endtask : test_host
   // run is about 8500 cycles
   always @(posedge clk_sys_i) begin
      cyc++;
      if (cyc == 40000) begin
         err_count++;
         wrap_up();
      end
   end
   initial begin
      wait_cyc(10);
      check("clock out in reset", {5'h0, dclk}, 8'h0);
      rstn_i = 1;
      test_bypass();
      test_rails();
      test_depth();
      test_host();
      wrap_up();
   end
endmodule : tb_top
